// ---- hw/cam_pkg.sv ----
// Constants, opcodes and carriers for the cog arithmetic and mux datapath.
// Assumes the surrounding core fetches, decodes conditions and operands.
// How it works
// - Masked copy writes not-Z into D bits where S is one; Z zero, C parity.
// - Absolute add adds abs(S) to D; Z zero result, C unsigned carry.
// - Absolute subtract takes abs(S) from D; Z zero, C unsigned borrow.
// - Carry sum adds -S when C set, else S; Z zero, C signed overflow.
// - Zero sum adds -S when Z set, else S; Z zero, C signed overflow.
// - Carry negate sets D to -S when C set, else S; C takes S bit 31.
package cam_pkg;
   localparam int DATA_W = 32;
   localparam int OP_W   = 6;
   localparam int COND_W = 4;
   localparam int ADR_W  = 9;
   localparam int CYCLES = 4;
   localparam logic [1:0] CNT_LAST = 2'h3;

   // Word field positions
   localparam int OP_MSB   = 31;
   localparam int WZ_BIT   = 25;
   localparam int WC_BIT   = 24;
   localparam int WR_BIT   = 23;
   localparam int IMM_BIT  = 22;
   localparam int COND_MSB = 21;
   localparam int D_MSB    = 17;
   localparam int S_MSB    = 8;

   localparam logic [5:0] OP_MASKED_COPY_NOT_ZERO = 6'h1f;
   localparam logic [5:0] OP_ADD_ABSOLUTE         = 6'h22;
   localparam logic [5:0] OP_SUB_ABSOLUTE         = 6'h23;
   localparam logic [5:0] OP_SUM_CARRY_COND       = 6'h24;
   localparam logic [5:0] OP_SUM_ZERO_COND        = 6'h26;
   localparam logic [5:0] OP_NEGATE_CARRY_COND    = 6'h2c;

   typedef struct packed {
      logic [OP_W-1:0]   opcode;
      logic              wr_z;
      logic              wr_c;
      logic              wr_result;
      logic              imm;
      logic [COND_W-1:0] cond;
      logic [ADR_W-1:0]  d_adr;
      logic [ADR_W-1:0]  s_adr;
   } cam_instr_s;

   typedef struct packed {
      logic [DATA_W-1:0] result;
      logic              z;
      logic              c;
   } cam_result_s;
endpackage

// ---- hw/cam_alu.sv ----
// Cog arithmetic and mux datapath: six two-operand operations plus flags.
// Assumes operands and the issue pulse come from logic on CLK.
`timescale 1ns/1ps
`default_nettype none
module cam_alu (
   input  wire logic                       CLK,
   input  wire logic                       RST_B,
   input  wire logic                       START,
   input  wire cam_pkg::cam_instr_s        INSTR,
   input  wire logic [cam_pkg::DATA_W-1:0] D_VAL,
   input  wire logic [cam_pkg::DATA_W-1:0] S_VAL,
   input  wire logic                       Z_IN,
   input  wire logic                       C_IN,
   output var  logic                       BUSY,
   output var  logic                       DONE,
   output var  logic                       KNOWN_OP,
   output var  cam_pkg::cam_result_s       RESULT
);
   import cam_pkg::*;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_ff;
   logic rst_ff;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_ff <= 1'b0;
         rst_ff      <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_ff      <= rst_meta_ff;
      end
   end
   wire rst_n = rst_ff;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [DATA_W-1:0] negate(input logic [DATA_W-1:0] v);
      negate = ~v + 32'h1;
   endfunction

   function automatic logic [DATA_W:0] add33(input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
      add33 = {1'b0, a} + {1'b0, b};
   endfunction

   function automatic logic ovf(input logic [DATA_W-1:0] a,
                                input logic [DATA_W-1:0] b,
                                input logic [DATA_W-1:0] r);
      ovf = (a[DATA_W-1] == b[DATA_W-1]) && (r[DATA_W-1] != a[DATA_W-1]);
   endfunction

   // ----------------------------------------
   // Four-clock sequencer
   // ----------------------------------------
   typedef enum logic {
      CAM_IDLE,
      CAM_EXEC
   } cam_state_e;

   cam_state_e state_ff;
   cam_state_e nxt_state;
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;

   // A start while executing is dropped, not queued; the core must wait
   wire busy = (state_ff == CAM_EXEC);
   wire take = START && !busy;
   wire last = busy && (cnt_ff == CNT_LAST);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         CAM_IDLE: begin
            if (START) begin
               nxt_state = CAM_EXEC;
               nxt_cnt   = 2'h0;
            end
         end
         CAM_EXEC: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (last) begin
               nxt_state = CAM_IDLE;
            end
         end
         default: begin
            nxt_state = CAM_IDLE;
            nxt_cnt   = 2'h0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= CAM_IDLE;
         cnt_ff   <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // ----------------------------------------
   // Operand latch
   // ----------------------------------------
   logic [OP_W-1:0]   op_ff;
   logic [DATA_W-1:0] d_ff;
   logic [DATA_W-1:0] s_ff;
   logic              z_ff;
   logic              c_ff;

   // Operands are held for the whole op, so the core may reuse its buses
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         op_ff <= 6'h0;
         d_ff  <= 32'h0;
         s_ff  <= 32'h0;
         z_ff  <= 1'b0;
         c_ff  <= 1'b0;
      end else if (take) begin
         op_ff <= INSTR.opcode;
         d_ff  <= D_VAL;
         s_ff  <= S_VAL;
         z_ff  <= Z_IN;
         c_ff  <= C_IN;
      end
   end

   // ----------------------------------------
   // Opcode decode
   // ----------------------------------------
   wire is_mux     = (op_ff == OP_MASKED_COPY_NOT_ZERO);
   wire is_add_abs = (op_ff == OP_ADD_ABSOLUTE);
   wire is_sub_abs = (op_ff == OP_SUB_ABSOLUTE);
   wire is_sum_c   = (op_ff == OP_SUM_CARRY_COND);
   wire is_sum_z   = (op_ff == OP_SUM_ZERO_COND);
   wire is_neg_c   = (op_ff == OP_NEGATE_CARRY_COND);
   // Anything else belongs to another unit and passes D through
   wire known      = is_mux || is_add_abs || is_sub_abs ||
                     is_sum_c || is_sum_z || is_neg_c;

   // ----------------------------------------
   // Datapath
   // ----------------------------------------
   wire [DATA_W-1:0] s_neg  = negate(s_ff);
   wire [DATA_W-1:0] s_abs  = s_ff[DATA_W-1] ? s_neg : s_ff;
   wire [DATA_W:0]   abs_add = add33(d_ff, s_abs);
   wire [DATA_W:0]   abs_sub = {1'b0, d_ff} - {1'b0, s_abs};
   wire [DATA_W-1:0] mux_res = (d_ff & ~s_ff) | ({DATA_W{~z_ff}} & s_ff);
   // Conditional add term, chosen by the flag that the opcode names
   wire              sum_flag = is_sum_z ? z_ff : c_ff;
   wire [DATA_W-1:0] sum_b   = sum_flag ? s_neg : s_ff;
   wire [DATA_W-1:0] sum_res = d_ff + sum_b;
   wire [DATA_W-1:0] negate_carry_conditioned    = c_ff ? s_neg : s_ff;

   // ----------------------------------------
   // Result select
   // ----------------------------------------
   logic [DATA_W-1:0] res;
   logic              cf;
   always_comb begin
      res = d_ff;
      cf  = c_ff;
      case (op_ff)
         OP_MASKED_COPY_NOT_ZERO: begin
            res = mux_res;
            cf  = ^mux_res;
         end
         OP_ADD_ABSOLUTE: begin
            res = abs_add[DATA_W-1:0];
            cf  = abs_add[DATA_W];
         end
         OP_SUB_ABSOLUTE: begin
            res = abs_sub[DATA_W-1:0];
            cf  = abs_sub[DATA_W];
         end
         OP_SUM_CARRY_COND: begin
            res = sum_res;
            cf  = ovf(d_ff, sum_b, sum_res);
         end
         OP_SUM_ZERO_COND: begin
            res = sum_res;
            cf  = ovf(d_ff, sum_b, sum_res);
         end
         OP_NEGATE_CARRY_COND: begin
            res = negate_carry_conditioned;
            cf  = s_ff[DATA_W-1];
         end
         default: begin
            // Opcodes outside this block keep D and the incoming carry
            res = d_ff;
            cf  = c_ff;
         end
      endcase
   end

   // ----------------------------------------
   // Flag results
   // ----------------------------------------
   wire res_zero = (res == 32'h0);
   wire nxt_z    = known ? res_zero : z_ff;
   wire nxt_busy = (nxt_state == CAM_EXEC);

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         BUSY <= 1'b0;
         DONE <= 1'b0;
      end else begin
         BUSY <= nxt_busy;
         DONE <= last;
      end
   end

   // Result and flags hold until the next op ends
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         KNOWN_OP <= 1'b0;
         RESULT   <= '0;
      end else if (last) begin
         KNOWN_OP      <= known;
         RESULT.result <= res;
         RESULT.z      <= nxt_z;
         RESULT.c      <= cf;
      end
   end
endmodule // cam_alu
`default_nettype wire

// ---- verif/cam_alu_properties.sv ----
// Assertions for cam_alu, bound from the bench.
// Sees only cam_alu ports; operands are captured at each take.
`timescale 1ns/1ps
`default_nettype none
module cam_alu_properties (
   input wire logic                 CLK,
   input wire logic                 RST_B,
   input wire logic                 START,
   input wire cam_pkg::cam_instr_s  INSTR,
   input wire logic [31:0]          D_VAL,
   input wire logic [31:0]          S_VAL,
   input wire logic                 Z_IN,
   input wire logic                 C_IN,
   input wire logic                 BUSY,
   input wire logic                 DONE,
   input wire logic                 KNOWN_OP,
   input wire cam_pkg::cam_result_s RESULT
);
   import cam_pkg::*;
   logic [5:0]  op_ff;
   logic [31:0] d_ff, s_ff;
   logic        z_ff, c_ff;
   wire         take = START && !BUSY;
   wire [31:0]  abs_s = s_ff[31] ? -s_ff : s_ff;
   wire         sum_op = op_ff == 6'h24 || op_ff == 6'h26;
   wire [31:0]  sum_t = ((op_ff == 6'h24) ? c_ff : z_ff) ? -s_ff : s_ff;
   // Operands held here, since the ports may change during the op
   always_ff @(posedge CLK)
      if (take) {op_ff, d_ff, s_ff, z_ff, c_ff}
         <= {INSTR.opcode, D_VAL, S_VAL, Z_IN, C_IN};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_busy_then_done: assert property (take |-> ##1 BUSY [*4] ##1 (DONE && !BUSY))
      else $error("busy or done timing off");
   a_done_single: assert property (DONE |=> !DONE)
      else $error("done longer than one cycle");
   a_zero_flag: assert property (DONE && KNOWN_OP |-> RESULT.z == (RESULT.result == 0))
      else $error("zero flag wrong");
   a_mux_bits: assert property (DONE && op_ff == 6'h1f |-> RESULT.c == ^RESULT.result
      && RESULT.result == (d_ff & ~s_ff | {32{~z_ff}} & s_ff)) else $error("mux wrong");
   a_abs_add: assert property (DONE && op_ff == 6'h22 |->
      {RESULT.c, RESULT.result} == {1'b0, d_ff} + abs_s) else $error("abs add wrong");
   a_abs_sub: assert property (DONE && op_ff == 6'h23 |->
      {RESULT.c, RESULT.result} == {1'b0, d_ff} - abs_s) else $error("abs sub wrong");
   a_sum_cond: assert property (DONE && sum_op |->
      RESULT.result == d_ff + sum_t && RESULT.c == (d_ff[31] == sum_t[31]
      && RESULT.result[31] != d_ff[31])) else $error("conditional sum wrong");
   a_neg_sign: assert property (DONE && op_ff == 6'h2c |-> RESULT.c == s_ff[31])
      else $error("negate carry wrong");
   cover property (take && DONE);
   cover property (DONE && op_ff == 6'h2c);
   cover property (DONE && RESULT.z);
   cover property (START && BUSY);
endmodule // cam_alu_properties
`default_nettype wire

// ---- verif/cam_alu_tb.sv ----
// Self-checking bench for cam_alu: random and corner operations.
// Assumes cam_pkg and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: %h", $time, a); end end
module cam_alu_tb;
   import cam_pkg::*;
   logic        CLK = 0, RST_B = 0, START = 0, Z_IN = 0, C_IN = 0;
   logic        BUSY, DONE, KNOWN_OP;
   logic [31:0] D_VAL = '0, S_VAL = '0;
   cam_instr_s  INSTR = '0;
   cam_result_s RESULT, e;
   int          fail_count = 0, num_checks = 0, seed = 32'hb2e5, n;
   logic [5:0]  ops [7] = '{6'h1f, 6'h22, 6'h23, 6'h24, 6'h26, 6'h2c, 6'h00};
   cam_alu cam_alu_i (.CLK, .RST_B, .START, .INSTR, .D_VAL, .S_VAL,
      .Z_IN, .C_IN, .BUSY, .DONE, .KNOWN_OP, .RESULT);
   initial forever #12.5 CLK = ~CLK;
   function automatic cam_result_s exp_res(logic [5:0] op,
         logic [31:0] d, s, logic z, c);
      logic [31:0] r, a, t;
      logic        f;
      a = s[31] ? -s : s;
      t = (op == 6'h24 && c || op == 6'h26 && z) ? -s : s;
      r = d;
      f = c;
      case (op)
         6'h1f: begin r = d & ~s | {32{~z}} & s; f = ^r; end
         6'h22: {f, r} = {1'b0, d} + a;
         6'h23: {f, r} = {1'b0, d} - a;
         6'h24, 6'h26: begin r = d + t; f = d[31] == t[31] && r[31] != d[31]; end
         6'h2c: begin r = c ? -s : s; f = s[31]; end
         default: ;
      endcase
      return '{r, op ? r == 0 : z, f};
   endfunction
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Run needs about 1500 cycles
   initial begin #100000; fail_count++; finish_test; end
   initial begin
      repeat (4) @(posedge CLK);
      #2 RST_B = 1;
      repeat (3) @(posedge CLK);
      #2;
      for (int i = 0; i < 300; i++) begin
         INSTR = $random(seed);
         INSTR.opcode = ops[i % 7];
         D_VAL = $random(seed);
         S_VAL = $random(seed);
         {Z_IN, C_IN} = 2'($random(seed));
         if (i % 5 == 0) S_VAL = 32'h8000_0000;
         if (i % 5 == 1) D_VAL = S_VAL;
         if (i % 5 == 2) D_VAL = -S_VAL;
         e = exp_res(INSTR.opcode, D_VAL, S_VAL, Z_IN, C_IN);
         // Raised in the cycle that done is high, so ops run back to back
         START = 1;
         @(posedge CLK);
         // Every third op retries a start while busy; it must be ignored
         #2 START = (i % 3 == 0);
         D_VAL = ~D_VAL;
         S_VAL = ~S_VAL;
         `CHK(BUSY, 1'b1)
         n = 0;
         while (DONE !== 1'b1 && n < 8) begin
            @(posedge CLK);
            #2 if (n == 0) START = 0;
            n++;
         end
         `CHK(n, 4)
         `CHK(KNOWN_OP, INSTR.opcode != 0)
         case (INSTR.opcode)
            6'h1f: `CHK(RESULT, e)
            6'h22: `CHK(RESULT, e)
            6'h23: `CHK(RESULT, e)
            6'h24: `CHK(RESULT, e)
            6'h26: `CHK(RESULT, e)
            6'h2c: `CHK(RESULT, e)
            default: `CHK(RESULT, e)
         endcase
      end
      finish_test;
   end
endmodule // cam_alu_tb
bind cam_alu cam_alu_properties cam_alu_properties_i (.CLK, .RST_B,
   .START, .INSTR, .D_VAL, .S_VAL, .Z_IN, .C_IN, .BUSY, .DONE, .KNOWN_OP,
   .RESULT);
`default_nettype wire
